// [verilog/sso_pkg.sv]
// Shared constants for the stepper status output block.
`default_nettype none
package sso_pkg;
  localparam int CLK_HZ = 10_000_000;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STO_TH = 8'h04;
  localparam logic [7:0] OFS_TEMP_TH = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  // Control register fields.
  localparam int CTRL_POL_LSB = 0;
  localparam int CTRL_POL_W = 6;
  localparam int CTRL_SC_EN = 6;
  localparam int CTRL_STO_EN = 7;
  localparam int CTRL_START_ACT = 8;
  localparam int CTRL_RUN_CMD = 9;
  localparam int CTRL_W = 9;
  // Polarity field order, also status flag order.
  localparam int IX_READY = 0;
  localparam int IX_SEQ = 1;
  localparam int IX_SC = 2;
  localparam int IX_STO = 3;
  localparam int IX_TEMP = 4;
  localparam int IX_WARN = 5;
  localparam int STAT_CFG_DONE = 6;
  localparam int STAT_STO_ARMED = 7;
  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam int STO_TH_W = 16;
  localparam logic [STO_TH_W-1:0] STO_TH_RST = 16'h0064;
  localparam int TEMP_W = 8;
  localparam logic [TEMP_W-1:0] TEMP_TH_RST = 8'h55;
  // Timing.
  localparam int EXCITE_MS = 500;
  localparam int EXCITE_CYC = (CLK_HZ / 1000) * EXCITE_MS;
  localparam int POWERON_US = 1000;
  localparam int POWERON_CYC = (CLK_HZ / 1_000_000) * POWERON_US;
  localparam int ECHO_MAX_HZ = 500_000;
  localparam int ECHO_PERIOD_CYC = (CLK_HZ + ECHO_MAX_HZ - 1) / ECHO_MAX_HZ;
  localparam int ECHO_HIGH_CYC = ECHO_PERIOD_CYC / 2;
  localparam int ECHO_LOW_CYC = ECHO_PERIOD_CYC - ECHO_HIGH_CYC;
  // Sequence control states.
  typedef enum logic [1:0] {
    SEQ_LAUNCH_CFG = 2'b00,
    SEQ_RUN = 2'b01,
    SEQ_IDLE = 2'b10
  } sso_seq_t;
endpackage : sso_pkg
`default_nettype wire

// [verilog/sso_echo_if.sv]
// Step and direction echo signals between the core and the pulse shaper.
`default_nettype none
interface sso_echo_if;
  logic step_req;
  logic dir_cmd;
  logic echo;
  logic dir_echo;
  modport shaper (input step_req, input dir_cmd, output echo,
    output dir_echo);
  modport core (output step_req, output dir_cmd, input echo,
    input dir_echo);
endinterface : sso_echo_if
`default_nettype wire

// [verilog/sso_step_echo.sv]
// Shapes internal step requests into echo pulses of bounded rate.
`default_nettype none
module sso_step_echo #(
  parameter int HIGH_CYC = sso_pkg::ECHO_HIGH_CYC,
  parameter int LOW_CYC = sso_pkg::ECHO_LOW_CYC,
  parameter int PEND_W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  sso_echo_if.shaper eif
);
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(HIGH_CYC - 1);
  localparam logic [CNT_W-1:0] LOW_LAST = CNT_W'(LOW_CYC - 1);
  localparam logic [PEND_W-1:0] PEND_MAX = '1;

  logic [PEND_W-1:0] pend_r;
  logic [CNT_W-1:0] cnt_r;
  logic busy_r;
  logic echo_r;
  logic dir_r;
  logic take;

  assign take = !busy_r && (pend_r != '0);
  assign eif.echo = echo_r;
  assign eif.dir_echo = dir_r;

  // Pending step count; an arriving step is never dropped by a take.
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_r <= '0;
    end else if (ce) begin
      if (eif.step_req && !take && pend_r != PEND_MAX) begin
        pend_r <= pend_r + 1'b1;
      end else if (!eif.step_req && take) begin
        pend_r <= pend_r - 1'b1;
      end
    end
  end

  // One echo pulse per step counted in pend_r, high then low, never faster than the limit.
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      echo_r <= 1'b0;
      cnt_r <= '0;
    end else if (ce) begin
      if (take) begin
        busy_r <= 1'b1;
        echo_r <= 1'b1;
        cnt_r <= '0;
      end else if (busy_r) begin
        if (echo_r && cnt_r == HIGH_LAST) begin
          echo_r <= 1'b0;
          cnt_r <= '0;
        end else if (!echo_r && cnt_r == LOW_LAST) begin
          busy_r <= 1'b0;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  // Direction follows the command that goes with the steps.
  always_ff @(posedge clk) begin
    if (rst) begin
      dir_r <= 1'b0;
    end else if (ce && !busy_r) begin
      dir_r <= eif.dir_cmd;
    end
  end
endmodule : sso_step_echo
`default_nettype wire

// [verilog/sso_top.sv]
// Status outputs, step echo and sequence launch of a stepper controller.
// Behaviour
// - Ready only when able and nothing blocks.
// - Ready off while sequence, motion, alarm.
// - Ready off for home, start, current-off, stop.
// - Abort blocks ready, except toggle start abort; the code blocks ready on abort in every start mode.
// - Ready off unexcited and just after power-on.
// - Each status output has polarity selection.
// - Sequence flag high while sequence executes.
// - Self-correct flag on corrected deviation, enabled.
// - Self-correct cleared by motion or current off.
// - Stepout when deviation reaches threshold, enabled.
// - Stepout armed after 500 ms excitation.
// - Stepout held off during homing.
// - Temperature flag above warning threshold.
// - Warning follows its cause, operation continues.
// - One echo pulse per step, 500 kHz; the code drops a step that arrives while 15 are already pending.
// - Direction echo follows internal direction.
// - Echo reflects corrected travel during correction.
// - Sequence starts by serial command or input.
// - Start-up sequence runs after every reset.
// - Start input launches on leading edge.
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`default_nettype none
module sso_top #(
  parameter int EXCITE_CYC = sso_pkg::EXCITE_CYC,
  parameter int POWERON_CYC = sso_pkg::POWERON_CYC,
  parameter int DEV_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins from outside.
  input wire logic home_in,
  input wire logic start_in,
  input wire logic current_off_in,
  input wire logic abort_in,
  input wire logic protective_stop_in,
  // Internal state of the motion core.
  input wire logic motor_moving,
  input wire logic alarm_active,
  input wire logic motor_excited,
  input wire logic homing_active,
  input wire logic encoder_present,
  input wire logic correction_done,
  input wire logic motion_cmd_exec,
  input wire logic [DEV_W-1:0] deviation_abs,
  input wire logic [sso_pkg::TEMP_W-1:0] driver_temperature,
  input wire logic warning_cause,
  input wire logic step_pulse,
  input wire logic dir_cmd,
  input wire logic seq_done,
  // Sequence control toward the sequence engine.
  output logic seq_launch,
  output logic seq_config_sel,
  output logic seq_abort,
  // Status pins.
  output logic ready_out,
  output logic seq_active_out,
  output logic self_correct_out,
  output logic stepout_out,
  output logic temp_warning_out,
  output logic warning_out,
  output logic step_echo_out,
  output logic dir_echo_out
);
  localparam int PIN_N = 5;
  localparam int P_HOME = 0;
  localparam int P_START = 1;
  localparam int P_CURRENT_OFF_IN = 2;
  localparam int P_ABORT = 3;
  localparam int P_PROTECTIVE_STOP_IN = 4;
  localparam int EXC_W = $clog2(EXCITE_CYC + 1);
  localparam int PON_W = $clog2(POWERON_CYC + 1);
  localparam logic [EXC_W-1:0] EXC_LAST = EXC_W'(EXCITE_CYC);
  localparam logic [PON_W-1:0] PON_LAST = PON_W'(POWERON_CYC);

  logic [PIN_N-1:0] pin_meta_r;
  logic [PIN_N-1:0] pin_r;
  logic start_prev_r;
  logic start_rise;
  logic start_fall;

  logic [sso_pkg::CTRL_W-1:0] ctrl_r;
  logic [sso_pkg::STO_TH_W-1:0] stepout_threshold;
  logic [sso_pkg::TEMP_W-1:0] temp_warning_threshold;
  logic run_cmd_r;
  logic [31:0] rd_data;
  logic wr_en;
  logic start_action_sel;
  logic self_correct_enable;
  logic stepout_detect_enable;
  logic [sso_pkg::CTRL_POL_W-1:0] pol_sel;

  sso_pkg::sso_seq_t seq_state_r;
  logic launch_r;
  logic cfg_sel_r;
  logic abort_r;
  logic cfg_done_r;

  logic [PON_W-1:0] pon_cnt_r;
  logic pon_done_r;
  logic [EXC_W-1:0] exc_cnt_r;
  logic sto_armed_r;
  logic self_correct_flag;
  logic [sso_pkg::CTRL_POL_W-1:0] flag;
  logic [sso_pkg::CTRL_POL_W-1:0] out_r;
  logic abort_blocks;
  logic start_blocks;

  sso_echo_if eif ();

  // Outside pins pass two flip-flops before use.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta_r <= '0;
      pin_r <= '0;
    end else if (ce) begin
      pin_meta_r <= {protective_stop_in, abort_in, current_off_in,
        start_in, home_in};
      pin_r <= pin_meta_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      start_prev_r <= 1'b0;
    end else if (ce) begin
      start_prev_r <= pin_r[P_START];
    end
  end

  assign start_rise = pin_r[P_START] && !start_prev_r;
  assign start_fall = !pin_r[P_START] && start_prev_r;

  assign start_action_sel = ctrl_r[sso_pkg::CTRL_START_ACT];
  assign self_correct_enable = ctrl_r[sso_pkg::CTRL_SC_EN];
  assign stepout_detect_enable = ctrl_r[sso_pkg::CTRL_STO_EN];
  assign pol_sel = ctrl_r[sso_pkg::CTRL_POL_LSB +: sso_pkg::CTRL_POL_W];

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // Register writes honour byte selects.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= sso_pkg::CTRL_RST;
      stepout_threshold <= sso_pkg::STO_TH_RST;
      temp_warning_threshold <= sso_pkg::TEMP_TH_RST;
    end else if (ce && wr_en) begin
      case (wb_adr_i)
        sso_pkg::OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            ctrl_r[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            ctrl_r[8] <= wb_dat_i[8];
          end
        end
        sso_pkg::OFS_STO_TH: begin
          if (wb_sel_i[0]) begin
            stepout_threshold[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            stepout_threshold[15:8] <= wb_dat_i[15:8];
          end
        end
        sso_pkg::OFS_TEMP_TH: begin
          if (wb_sel_i[0]) begin
            temp_warning_threshold <= wb_dat_i[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // serial run command is a self-clearing write.
  always_ff @(posedge clk) begin
    if (rst) begin
      run_cmd_r <= 1'b0;
    end else if (ce) begin
      run_cmd_r <= wr_en && wb_adr_i == sso_pkg::OFS_CTRL && wb_sel_i[1]
        && wb_dat_i[sso_pkg::CTRL_RUN_CMD];
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      sso_pkg::OFS_CTRL: rd_data[sso_pkg::CTRL_W-1:0] = ctrl_r;
      sso_pkg::OFS_STO_TH: rd_data[15:0] = stepout_threshold;
      sso_pkg::OFS_TEMP_TH: rd_data[7:0] = temp_warning_threshold;
      sso_pkg::OFS_STATUS: begin
        rd_data[sso_pkg::CTRL_POL_W-1:0] = flag;
        rd_data[sso_pkg::STAT_CFG_DONE] = cfg_done_r;
        rd_data[sso_pkg::STAT_STO_ARMED] = sto_armed_r;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Single-wait-state answer; unmapped reads return zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

  // Sequence control: start-up sequence first, then launches.
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_state_r <= sso_pkg::SEQ_LAUNCH_CFG;
      launch_r <= 1'b0;
      cfg_sel_r <= 1'b0;
      abort_r <= 1'b0;
      cfg_done_r <= 1'b0;
    end else if (ce) begin
      launch_r <= 1'b0;
      abort_r <= 1'b0;
      case (seq_state_r)
        sso_pkg::SEQ_LAUNCH_CFG: begin
          launch_r <= 1'b1;
          cfg_sel_r <= 1'b1;
          seq_state_r <= sso_pkg::SEQ_RUN;
        end
        sso_pkg::SEQ_RUN: begin
          if (seq_done) begin
            cfg_done_r <= 1'b1;
            seq_state_r <= sso_pkg::SEQ_IDLE;
          end else if (pin_r[P_ABORT] || pin_r[P_PROTECTIVE_STOP_IN]
              || (start_action_sel && start_fall)) begin
            abort_r <= 1'b1;
            cfg_done_r <= 1'b1;
            seq_state_r <= sso_pkg::SEQ_IDLE;
          end
        end
        sso_pkg::SEQ_IDLE: begin
          if ((run_cmd_r || start_rise) && !pin_r[P_ABORT]
              && !pin_r[P_PROTECTIVE_STOP_IN] && !alarm_active) begin
            launch_r <= 1'b1;
            cfg_sel_r <= 1'b0;
            seq_state_r <= sso_pkg::SEQ_RUN;
          end
        end
        default: seq_state_r <= sso_pkg::SEQ_IDLE;
      endcase
    end
  end

  assign seq_launch = launch_r;
  assign seq_config_sel = cfg_sel_r;
  assign seq_abort = abort_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      pon_cnt_r <= '0;
      pon_done_r <= 1'b0;
    end else if (ce && !pon_done_r) begin
      if (pon_cnt_r == PON_LAST) begin
        pon_done_r <= 1'b1;
      end else begin
        pon_cnt_r <= pon_cnt_r + 1'b1;
      end
    end
  end

  // excitation must last before stepout arms.
  always_ff @(posedge clk) begin
    if (rst) begin
      exc_cnt_r <= '0;
      sto_armed_r <= 1'b0;
    end else if (ce) begin
      if (!motor_excited) begin
        exc_cnt_r <= '0;
        sto_armed_r <= 1'b0;
      end else if (exc_cnt_r == EXC_LAST) begin
        sto_armed_r <= 1'b1;
      end else begin
        exc_cnt_r <= exc_cnt_r + 1'b1;
      end
    end
  end

  // set on corrected deviation when enabled.
  // cleared by next motion or current off; set wins.
  always_ff @(posedge clk) begin
    if (rst) begin
      self_correct_flag <= 1'b0;
    end else if (ce) begin
      if (correction_done && encoder_present && self_correct_enable) begin
        self_correct_flag <= 1'b1;
      end else if (motion_cmd_exec || pin_r[P_CURRENT_OFF_IN] || !motor_excited) begin
        self_correct_flag <= 1'b0;
      end
    end
  end

  // abort pin blocks ready in every start action setting.
  assign abort_blocks = pin_r[P_ABORT];
  assign start_blocks = pin_r[P_START];

  always_comb begin
    // home, start, current-off and stop block.
    flag[sso_pkg::IX_READY] = seq_state_r == sso_pkg::SEQ_IDLE
      && !motor_moving && !alarm_active
      && !pin_r[P_HOME] && !start_blocks
      && !pin_r[P_CURRENT_OFF_IN] && !abort_blocks && !pin_r[P_PROTECTIVE_STOP_IN]
      && motor_excited && pon_done_r;
    flag[sso_pkg::IX_SEQ] = seq_state_r != sso_pkg::SEQ_IDLE;
    flag[sso_pkg::IX_SC] = self_correct_flag;
    // threshold reached with encoder and enable.
    flag[sso_pkg::IX_STO] = encoder_present && stepout_detect_enable
      && sto_armed_r && !homing_active
      && deviation_abs >= DEV_W'(stepout_threshold);
    flag[sso_pkg::IX_TEMP] = driver_temperature > temp_warning_threshold;
    flag[sso_pkg::IX_WARN] = warning_cause;
  end

  // per-signal polarity applied to each flag.
  always_ff @(posedge clk) begin
    if (rst) begin
      out_r <= '0;
    end else if (ce) begin
      out_r <= flag ^ pol_sel;
    end
  end

  assign ready_out = out_r[sso_pkg::IX_READY];
  assign seq_active_out = out_r[sso_pkg::IX_SEQ];
  assign self_correct_out = out_r[sso_pkg::IX_SC];
  assign stepout_out = out_r[sso_pkg::IX_STO];
  assign temp_warning_out = out_r[sso_pkg::IX_TEMP];
  assign warning_out = out_r[sso_pkg::IX_WARN];

  // every internal step becomes one echo pulse, except a step that arrives while 15 are already pending.
  // correction steps pass as they are generated.
  assign eif.step_req = step_pulse;
  assign eif.dir_cmd = dir_cmd;

  sso_step_echo #(
    .HIGH_CYC(sso_pkg::ECHO_HIGH_CYC),
    .LOW_CYC(sso_pkg::ECHO_LOW_CYC),
    .PEND_W(4)
  ) u_echo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .eif(eif.shaper)
  );

  assign step_echo_out = eif.echo;
  assign dir_echo_out = eif.dir_echo;
endmodule : sso_top
`default_nettype wire

// [sim/sso_top_sva.sv]
// Assertion checker for the stepper status output block.
`default_nettype none
module sso_top_sva #(
  parameter int EXCITE_CYC = 50,
  parameter int POWERON_CYC = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic home_in,
  input wire logic start_in,
  input wire logic current_off_in,
  input wire logic abort_in,
  input wire logic protective_stop_in,
  input wire logic motor_moving,
  input wire logic alarm_active,
  input wire logic motor_excited,
  input wire logic homing_active,
  input wire logic correction_done,
  input wire logic motion_cmd_exec,
  input wire logic [sso_pkg::TEMP_W-1:0] driver_temperature,
  input wire logic warning_cause,
  input wire logic seq_launch,
  input wire logic seq_config_sel,
  input wire logic ready_out,
  input wire logic seq_active_out,
  input wire logic self_correct_out,
  input wire logic stepout_out,
  input wire logic temp_warning_out,
  input wire logic warning_out,
  input wire logic step_echo_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [5:0] pol_r;
  logic [5:0] pol_q;
  logic [7:0] th_r;
  logic [7:0] gap_r;
  logic tq_r;
  logic wr;
  logic pins;
  int up_r;
  int exc_r;
  assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign pins = home_in || start_in || current_off_in || abort_in
    || protective_stop_in;
  // Tracks polarity and threshold settings as the bus writes them.
  always_ff @(posedge clk) begin
    if (rst) begin
      pol_r <= 6'h00;
      th_r <= sso_pkg::TEMP_TH_RST;
    end else if (wr && wb_adr_i == sso_pkg::OFS_CTRL) begin
      pol_r <= wb_dat_i[5:0];
    end else if (wr && wb_adr_i == sso_pkg::OFS_TEMP_TH) begin
      th_r <= wb_dat_i[7:0];
    end
  end
  // Delayed copies and cycle counters.
  always_ff @(posedge clk) begin
    if (rst) begin
      pol_q <= 6'h00;
      tq_r <= 1'b0;
      up_r <= 0;
      exc_r <= 0;
      gap_r <= 8'hFF;
    end else begin
      pol_q <= pol_r;
      tq_r <= driver_temperature > th_r;
      if (up_r < POWERON_CYC) up_r <= up_r + 1;
      if (!motor_excited) exc_r <= 0;
      else if (exc_r < EXCITE_CYC + 2) exc_r <= exc_r + 1;
      if ($rose(step_echo_out)) gap_r <= 8'h01;
      else if (gap_r != 8'hFF) gap_r <= gap_r + 8'h01;
    end
  end
  ready_busy_a: assert property (
    (motor_moving || alarm_active) |=> ready_out == pol_q[0])
    else $error("ready shown while moving or in alarm");
  ready_pins_a: assert property (
    pins [*4] |-> ready_out == pol_q[0])
    else $error("ready shown while a blocking pin is on");
  ready_power_a: assert property (
    (up_r < POWERON_CYC || !motor_excited) |=> ready_out == pol_q[0])
    else $error("ready shown unexcited or after power-on");
  seq_run_a: assert property (
    seq_launch |-> ##[1:2] seq_active_out != pol_q[1])
    else $error("sequence flag missing after launch");
  startup_seq_a: assert property (
    $fell(rst) |-> ##[0:2] (seq_launch && seq_config_sel))
    else $error("start-up sequence not launched");
  sc_clear_a: assert property (
    (motion_cmd_exec && !correction_done) ##1 !correction_done
    |=> self_correct_out == pol_q[2])
    else $error("self-correct flag kept after motion");
  sto_homing_a: assert property (
    homing_active |=> stepout_out == pol_q[3])
    else $error("stepout shown while homing");
  sto_arm_a: assert property (
    stepout_out != pol_q[3] |-> exc_r >= EXCITE_CYC)
    else $error("stepout shown before excitation time");
  temp_warn_a: assert property (
    temp_warning_out == (tq_r ^ pol_q[4]))
    else $error("temperature flag wrong");
  warn_follow_a: assert property (
    warning_out == ($past(warning_cause) ^ pol_q[5]))
    else $error("warning flag does not follow its cause");
  echo_rate_a: assert property (
    $rose(step_echo_out) |-> gap_r >= sso_pkg::ECHO_PERIOD_CYC)
    else $error("echo pulses too close");
  cover property (seq_launch && !seq_config_sel);
  cover property ($rose(stepout_out));
  cover property ($rose(step_echo_out));
endmodule : sso_top_sva
bind sso_top sso_top_sva #(
  .EXCITE_CYC(EXCITE_CYC),
  .POWERON_CYC(POWERON_CYC)
) u_sso_top_sva (.*);
`default_nettype wire

// [sim/sso_host_model.sv]
// Host controller model that launches sequences through the start pin.
`default_nettype none
module sso_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic ready_out,
  input wire logic host_go,
  output logic start_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pend_r;
  logic [3:0] hold_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_r <= 1'b0;
      hold_r <= 4'h0;
      start_in <= 1'b0;
    end else if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
      start_in <= hold_r != 4'h1;
    end else if (pend_r && ready_out) begin
      pend_r <= 1'b0;
      hold_r <= 4'h6;
      start_in <= 1'b1;
    end else if (host_go) begin
      pend_r <= 1'b1;
    end
  end
endmodule : sso_host_model
`default_nettype wire

// [sim/sso_top_bench.sv]
// Self-checking bench for the stepper status output block.
`default_nettype none
module sso_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EXC = 50;
  localparam int PON = 20;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic wb_ack_o, home_in, start_in, current_off_in, abort_in;
  logic protective_stop_in, motor_moving, alarm_active, motor_excited;
  logic [6:0] blk = 7'h00;
  logic homing_active = 1'b0, encoder_present = 1'b0, host_go = 1'b0;
  logic correction_done = 1'b0, motion_cmd_exec = 1'b0;
  logic [15:0] deviation_abs = 16'h0000;
  logic [7:0] driver_temperature = 8'h00;
  logic warning_cause = 1'b0, step_pulse = 1'b0, dir_cmd = 1'b0;
  logic seq_done = 1'b0, echo_q = 1'b0, last_cfg = 1'b0;
  logic seq_launch, seq_config_sel, seq_abort, ready_out, seq_active_out;
  logic self_correct_out, stepout_out, temp_warning_out, warning_out;
  logic step_echo_out, dir_echo_out;
  int miscompares = 0, comparisons = 0, nlaunch = 0, nechoes = 0;
  int nabort = 0;
  logic [7:0] radr [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
  logic [31:0] rexp [4] = '{32'h0, 32'h64, 32'h55, 32'h0};
  assign home_in = blk[0];
  assign current_off_in = blk[1];
  assign abort_in = blk[2];
  assign protective_stop_in = blk[3];
  assign motor_moving = blk[4];
  assign alarm_active = blk[5];
  assign motor_excited = !blk[6];
  sso_top #(.EXCITE_CYC(EXC), .POWERON_CYC(PON)) u_sso_top (.*);
  sso_host_model u_sso_host_model (.*);
  always #50 clk = ~clk;
  always @(posedge clk) begin
    echo_q <= step_echo_out;
    if (step_echo_out && !echo_q) nechoes <= nechoes + 1;
    if (seq_abort) nabort <= nabort + 1;
    if (seq_launch) begin
      nlaunch <= nlaunch + 1;
      last_cfg <= seq_config_sel;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_sel_i <= 4'h0;
  endtask : wb
  task automatic fin(input string nm);
    $display("test %s finished", nm);
  endtask : fin
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  task automatic end_seq;
    seq_done <= 1'b1;
    tick(1);
    seq_done <= 1'b0;
    tick(5);
  endtask : end_seq
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    results();
  end
  initial begin
    tick(12);
    rst <= 1'b0;
    tick(5);
    chk("boot launch", 32'h1, nlaunch);
    chk("boot cfg", 32'h1, last_cfg);
    chk("boot seq", 32'h1, seq_active_out);
    tick(PON);
    chk("ready in seq", 32'h0, ready_out);
    end_seq();
    chk("ready", 32'h1, ready_out);
    fin("startup");
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, radr[i], 32'h0);
      chk("reg reset", rexp[i], rdat);
    end
    fin("registers");
    for (int i = 0; i < 7; i++) begin
      blk <= 7'h01 << i;
      tick(6);
      chk("ready blocked", 32'h0, ready_out);
      blk <= 7'h00;
      tick(6);
      chk("ready back", 32'h1, ready_out);
    end
    fin("blockers");
    wb(1'b1, sso_pkg::OFS_CTRL, 32'h3F);
    tick(3);
    chk("ready inv", 32'h0, ready_out);
    chk("warn inv", 32'h1, warning_out);
    chk("seq inv", 32'h1, seq_active_out);
    wb(1'b1, sso_pkg::OFS_CTRL, 32'h0);
    fin("polarity");
    wb(1'b1, sso_pkg::OFS_CTRL, 32'h200);
    tick(6);
    chk("run launch", 32'h2, nlaunch);
    chk("run cfg", 32'h0, last_cfg);
    chk("running", 32'h1, seq_active_out);
    chk("ready run", 32'h0, ready_out);
    end_seq();
    chk("seq end", 32'h0, seq_active_out);
    host_go <= 1'b1;
    tick(1);
    host_go <= 1'b0;
    tick(15);
    chk("pin launch", 32'h3, nlaunch);
    end_seq();
    chk("ready idle", 32'h1, ready_out);
    wb(1'b1, sso_pkg::OFS_CTRL, 32'h200);
    tick(4);
    blk <= 7'h04;
    tick(6);
    chk("abort pulse", 32'h1, nabort);
    chk("abort seq", 32'h0, seq_active_out);
    chk("ready abort", 32'h0, ready_out);
    blk <= 7'h00;
    tick(6);
    fin("launch");
    driver_temperature <= 8'h55;
    tick(3);
    chk("temp at th", 32'h0, temp_warning_out);
    driver_temperature <= 8'h56;
    warning_cause <= 1'b1;
    tick(3);
    chk("temp above", 32'h1, temp_warning_out);
    chk("warn", 32'h1, warning_out);
    chk("ready warn", 32'h1, ready_out);
    warning_cause <= 1'b0;
    tick(3);
    chk("warn gone", 32'h0, warning_out);
    fin("warnings");
    encoder_present <= 1'b1;
    correction_done <= 1'b1;
    tick(1);
    correction_done <= 1'b0;
    tick(3);
    chk("sc off", 32'h0, self_correct_out);
    wb(1'b1, sso_pkg::OFS_CTRL, 32'hC0);
    correction_done <= 1'b1;
    tick(1);
    correction_done <= 1'b0;
    tick(3);
    chk("sc set", 32'h1, self_correct_out);
    motion_cmd_exec <= 1'b1;
    tick(1);
    motion_cmd_exec <= 1'b0;
    tick(3);
    chk("sc motion", 32'h0, self_correct_out);
    correction_done <= 1'b1;
    tick(1);
    correction_done <= 1'b0;
    blk <= 7'h40;
    tick(3);
    chk("sc current", 32'h0, self_correct_out);
    blk <= 7'h00;
    fin("selfcorrect");
    wb(1'b1, sso_pkg::OFS_STO_TH, 32'h10);
    deviation_abs <= 16'h0010;
    tick(20);
    chk("sto unarmed", 32'h0, stepout_out);
    tick(EXC);
    chk("sto", 32'h1, stepout_out);
    deviation_abs <= 16'h000F;
    tick(3);
    chk("sto below", 32'h0, stepout_out);
    deviation_abs <= 16'h0010;
    homing_active <= 1'b1;
    tick(3);
    chk("sto homing", 32'h0, stepout_out);
    homing_active <= 1'b0;
    fin("stepout");
    dir_cmd <= 1'b1;
    tick(2);
    step_pulse <= 1'b1;
    tick(3);
    step_pulse <= 1'b0;
    tick(80);
    chk("echo count", 32'h3, nechoes);
    chk("dir echo", 32'h1, dir_echo_out);
    fin("echo");
    results();
  end
endmodule : sso_top_bench
`default_nettype wire
